// ==== core/ddr3_ca_pkg.sv ====
// Shared types and constants for the DDR3 command/address pin controller.
// Assumes the memory clock pair is produced from clk outside this package.
package ddr3_ca_pkg;

  localparam int ADDR_W    = 15;
  localparam int BANK_W    = 3;
  localparam int NUM_BANKS = 8;
  localparam int MR_SEL_W  = 2;
  localparam int AP_BIT    = 10;
  localparam int BC_BIT    = 12;

  // Command codes on {RAS#, CAS#, WE#} while chip select is low.
  localparam logic [2:0] CODE_MRS = 3'h0;
  localparam logic [2:0] CODE_REF = 3'h1;
  localparam logic [2:0] CODE_PRE = 3'h2;
  localparam logic [2:0] CODE_ACT = 3'h3;
  localparam logic [2:0] CODE_WR  = 3'h4;
  localparam logic [2:0] CODE_RD  = 3'h5;
  localparam logic [2:0] CODE_NOP = 3'h7;

  typedef enum logic [3:0] {
    OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_PREA, OP_MRS, OP_REF,
    OP_PDE, OP_PDX, OP_SRE, OP_SRX
  } cmdOp_t;

  typedef enum logic [1:0] {
    ST_RESET, ST_IDLE, ST_PDOWN, ST_SELFREF
  } ctrlState_t;

  typedef struct packed {
    cmdOp_t              op;
    logic [BANK_W-1:0]   bank;
    logic [ADDR_W-1:0]   addr;
    logic                autoPre;
    logic                burstChop;
  } cmdReq_t;

  typedef struct packed {
    logic                resetN;
    logic                cke;
    logic                csN;
    logic                rasN;
    logic                casN;
    logic                weN;
    logic [BANK_W-1:0]   ba;
    logic [ADDR_W-1:0]   addr;
    logic                odt;
    logic                dm;
  } ddrPins_t;

  // Pin levels while in reset: device held in reset, CKE low, deselected.
  localparam ddrPins_t PINS_RESET = '{
    resetN: 1'b0, cke: 1'b0, csN: 1'b1, rasN: 1'b1, casN: 1'b1,
    weN: 1'b1, ba: 3'h0, addr: 15'h0000, odt: 1'b0, dm: 1'b0
  };

endpackage : ddr3_ca_pkg

// ==== core/ddr3_cmd_encoder.sv ====
// Command encoder: maps a requested operation to chip select and command pins.
// Assumes the caller registers the outputs before they reach the pins.
`timescale 1ns/10ps
module ddr3_cmd_encoder
  import ddr3_ca_pkg::*;
(
  input  wire cmdOp_t     op,
  output logic            csN,
  output logic [2:0]      code
);

  // Power-down entry and both exits are issued as deselect.
  always_comb begin
    csN  = 1'b0;
    code = CODE_NOP;
    case (op)
      OP_ACT:           code = CODE_ACT;
      OP_RD:            code = CODE_RD;
      OP_WR:            code = CODE_WR;
      OP_PRE, OP_PREA:  code = CODE_PRE;
      OP_MRS:           code = CODE_MRS;
      OP_REF, OP_SRE:   code = CODE_REF;
      OP_NOP:           code = CODE_NOP;
      default:          csN  = 1'b1;
    endcase
  end

endmodule : ddr3_cmd_encoder

// ==== core/ddr3_ca_ctrl.sv ====
// Host-side controller for the DDR3 command, address and control pins.
// Assumes the memory clock is clk forwarded so that the device samples each
// pin value at the rising edge following the one that launched it.
`timescale 1ns/10ps

// Functional notes
// - ACTIVATE sends row; READ/WRITE send column and A10 auto-precharge.
// - PRECHARGE with A10 low closes the named bank, high closes all.
// - Mode register load carries the op-code on the address pins.
// - With on-the-fly chop on, A12 high means BL8, low means BC4.
// - Bank pins name the bank for ACTIVATE, READ, WRITE, single PRECHARGE.
// - During mode register load the bank pins pick MR0 to MR3.
// - All control and address pins are sampled at the rising clock crossing.
// - CKE high enables device circuitry and clocks, low disables them.
// - CKE low: idle banks give precharge PD or self refresh; else active PD.
// - CKE sampled on clock for power-down and SR entry; SR exit is async.
// - Commands only count with chip select low; high masks everything.
// - Command is RAS#, CAS#, WE# with CS#, sampled on one edge.
// - Write data sampled with DM high is not written.
// - ODT high enables termination on data, strobes and mask.
// - Reset is active low, asserted and released asynchronously.
module ddr3_ca_ctrl
  import ddr3_ca_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     ce,
  input  wire cmdReq_t  req,
  input  wire logic     cmdValid,
  output logic          cmdReady,
  output logic          cmdReject,
  input  wire logic     otfChopEn,
  input  wire logic     memResetReq,
  input  wire logic     odtReq,
  input  wire logic     wrMask,
  output ddrPins_t      pins,
  output logic          pdActive
);

  typedef struct packed {
    ctrlState_t             state;
    logic [NUM_BANKS-1:0]   openBanks;
    logic                   ready;
    logic                   reject;
    logic                   pdActive;
    ddrPins_t               pins;
  } ctrlRegs_t;

  localparam ctrlRegs_t REGS_RESET = '{
    state: ST_RESET, openBanks: 8'h00, ready: 1'b0, reject: 1'b0,
    pdActive: 1'b0, pins: PINS_RESET
  };

  ctrlRegs_t   regs_q;
  ctrlRegs_t   regs_d;
  logic        encCsN;
  logic [2:0]  encCode;
  logic        take;

  // Whether a request may be issued from the idle state given open rows.
  function automatic logic legalInIdle(
    input cmdOp_t               op,
    input logic [NUM_BANKS-1:0] open,
    input logic [BANK_W-1:0]    bank
  );
    logic allIdle;
    allIdle = (open == '0);
    case (op)
      OP_ACT:                  legalInIdle = !open[bank];
      OP_RD, OP_WR:            legalInIdle = open[bank];
      OP_MRS, OP_REF, OP_SRE:  legalInIdle = allIdle;
      OP_PDX, OP_SRX:          legalInIdle = 1'b0;
      default:                 legalInIdle = 1'b1;
    endcase
  endfunction : legalInIdle

  ddr3_cmd_encoder u_enc (
    .op   (req.op),
    .csN  (encCsN),
    .code (encCode)
  );

  assign take = cmdValid && regs_q.ready;

  // Next-state logic. Every pin is computed here and registered, so each
  // value holds for a full cycle around the device's sampling edge.
  always_comb begin
    regs_d = regs_q;
    if (ce) begin
      regs_d.reject    = 1'b0;
      regs_d.pins.csN  = 1'b1;
      regs_d.pins.rasN = 1'b1;
      regs_d.pins.casN = 1'b1;
      regs_d.pins.weN  = 1'b1;
      regs_d.pins.dm   = wrMask;
      // Termination is not requested after the first self refresh cycle; the pin is unheard.
      regs_d.pins.odt  = odtReq && (regs_q.state != ST_SELFREF);
      if (memResetReq) begin
        regs_d.state      = ST_RESET;
        regs_d.openBanks  = '0;
        regs_d.pins       = PINS_RESET;
      end else begin
        case (regs_q.state)
          ST_RESET: begin
            regs_d.pins.resetN = 1'b1;
            regs_d.pins.cke    = 1'b1;
            regs_d.state       = ST_IDLE;
          end
          ST_IDLE: begin
            if (take && !legalInIdle(req.op, regs_q.openBanks, req.bank)) begin
              regs_d.reject = 1'b1;
            end else if (take) begin
              // Code and select are launched together on one edge.
              regs_d.pins.csN = encCsN;
              {regs_d.pins.rasN, regs_d.pins.casN, regs_d.pins.weN} = encCode;
              case (req.op)
                OP_ACT: begin
                  regs_d.pins.ba   = req.bank;
                  regs_d.pins.addr = req.addr;
                  regs_d.openBanks[req.bank] = 1'b1;
                end
                OP_RD, OP_WR: begin
                  regs_d.pins.ba   = req.bank;
                  regs_d.pins.addr = req.addr;
                  regs_d.pins.addr[AP_BIT] = req.autoPre;
                  // Without on-the-fly chop the device ignores A12; hold BL8.
                  regs_d.pins.addr[BC_BIT] =
                    otfChopEn ? !req.burstChop : 1'b1;
                  if (req.autoPre) begin
                    regs_d.openBanks[req.bank] = 1'b0;
                  end
                end
                OP_PRE: begin
                  regs_d.pins.ba   = req.bank;
                  regs_d.pins.addr = '0;
                  regs_d.pins.addr[AP_BIT] = 1'b0;
                  regs_d.openBanks[req.bank] = 1'b0;
                end
                OP_PREA: begin
                  regs_d.pins.addr = '0;
                  regs_d.pins.addr[AP_BIT] = 1'b1;
                  regs_d.openBanks = '0;
                end
                OP_MRS: begin
                  regs_d.pins.ba   = BANK_W'(req.bank[MR_SEL_W-1:0]);
                  regs_d.pins.addr = req.addr;
                end
                OP_PDE: begin
                  regs_d.pins.cke = 1'b0;
                  regs_d.pdActive = (regs_q.openBanks != '0);
                  regs_d.state    = ST_PDOWN;
                end
                OP_SRE: begin
                  regs_d.pins.cke = 1'b0;
                  regs_d.state    = ST_SELFREF;
                end
                default: begin
                end
              endcase
            end
          end
          ST_PDOWN: begin
            // Only the exit is accepted; the device's command inputs are off.
            if (take && req.op == OP_PDX) begin
              regs_d.pins.cke = 1'b1;
              regs_d.pdActive = 1'b0;
              regs_d.state    = ST_IDLE;
            end else if (take) begin
              regs_d.reject = 1'b1;
            end
          end
          ST_SELFREF: begin
            // The device sees CKE rise without a clock; no code is sent.
            if (take && req.op == OP_SRX) begin
              regs_d.pins.cke = 1'b1;
              regs_d.state    = ST_IDLE;
            end else if (take) begin
              regs_d.reject = 1'b1;
            end
          end
          default: regs_d.state = ST_RESET;
        endcase
      end
      regs_d.ready = (regs_d.state != ST_RESET);
    end
  end

  // State register; the clock enable freezes it through the copy above.
  always_ff @(posedge clk) begin
    if (rst) begin
      regs_q <= REGS_RESET;
    end else begin
      regs_q <= regs_d;
    end
  end

  // Outputs come straight from the state register.
  assign pins      = regs_q.pins;
  assign cmdReady  = regs_q.ready;
  assign cmdReject = regs_q.reject;
  assign pdActive  = regs_q.pdActive;

  // Helper terms for the checks below.
  logic issue;
  assign issue = ce && take && !memResetReq && regs_q.state == ST_IDLE &&
                 legalInIdle(req.op, regs_q.openBanks, req.bank);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_act_row_pins: assert property (issue && req.op == OP_ACT |=>
      !pins.csN && !pins.rasN && pins.casN && pins.weN &&
      pins.addr == $past(req.addr) && pins.ba == $past(req.bank))
    else $error("activate pins wrong");
  a_rw_autopre: assert property (
      issue && (req.op == OP_RD || req.op == OP_WR) |=>
      pins.addr[AP_BIT] == $past(req.autoPre) && !pins.casN)
    else $error("auto-precharge bit wrong");
  a_pre_bank_sel: assert property (issue && req.op == OP_PRE |=>
      !pins.addr[AP_BIT] && pins.ba == $past(req.bank) && !pins.weN)
    else $error("single precharge wrong");
  a_prea_all_idle: assert property (issue && req.op == OP_PREA |=>
      pins.addr[AP_BIT] && !pins.csN && regs_q.openBanks == '0)
    else $error("precharge all wrong");
  a_mrs_opcode: assert property (issue && req.op == OP_MRS |=>
      pins.addr == $past(req.addr) && !pins.rasN && !pins.casN)
    else $error("mode load op-code wrong");
  a_mrs_select: assert property (issue && req.op == OP_MRS |=>
      pins.ba == BANK_W'($past(req.bank[MR_SEL_W-1:0])))
    else $error("mode register select wrong");
  a_burst_chop: assert property (
      issue && otfChopEn && (req.op == OP_RD || req.op == OP_WR) |=>
      pins.addr[BC_BIT] == !$past(req.burstChop))
    else $error("burst chop bit wrong");
  a_pd_kind: assert property (issue && req.op == OP_PDE |=>
      !pins.cke && pdActive == ($past(regs_q.openBanks) != '0))
    else $error("power-down kind wrong");
  a_sr_idle: assert property (issue && req.op == OP_SRE |=>
      !pins.cke && !pins.csN && pins.casN == 1'b0 && regs_q.openBanks == '0)
    else $error("self refresh entry wrong");
  a_desel_idle: assert property (ce && !issue |=> pins.csN)
    else $error("chip select low without command");
  a_reset_pin: assert property (ce && memResetReq |=>
      !pins.resetN && !pins.cke && pins.csN && !cmdReady)
    else $error("reset pin not asserted");
  // A memory reset parks the mask pin low and every other pin at its reset level.
  a_dm_follow: assert property (ce |=>
      pins.dm == ($past(wrMask) && !$past(memResetReq)))
    else $error("mask pin does not follow");
  a_odt_follow: assert property (
      ce && regs_q.state == ST_IDLE && !memResetReq |=>
      pins.odt == $past(odtReq))
    else $error("termination pin does not follow");

  c_activate:   cover property (issue && req.op == OP_ACT);
  c_active_pd:  cover property (issue && req.op == OP_PDE &&
                                regs_q.openBanks != '0);
  c_sr_cycle:   cover property (regs_q.state == ST_SELFREF ##[1:20]
                                regs_q.state == ST_IDLE);
  c_reject:     cover property (cmdReject);

endmodule : ddr3_ca_ctrl

// ==== tb/ddr3_dev_model.sv ====
// Behavioural DDR3 device seen from its command and address balls.
// Assumes pins are launched on one clk edge and sampled on the next.
`timescale 1ns/10ps
module ddr3_dev_model
  import ddr3_ca_pkg::*;
(
  input  wire logic            clk,
  input  wire ddrPins_t        pins,
  input  wire logic            otfOn,
  output logic [NUM_BANKS-1:0] openBanks,
  output logic [ADDR_W-1:0]    modeOp,
  output logic [1:0]           modeSel,
  output logic                 fullBurst
);
  logic       ckeQ;
  logic       termOn;
  logic       maskNow;
  logic       activePd;
  logic [2:0] code;

  // The command is the three strobes taken together with chip select.
  assign code = {pins.rasN, pins.casN, pins.weN};

  // Self refresh exit is taken on the clock here, a simplification of the
  // asynchronous wake-up that is harmless because the host waits anyway.
  always @(posedge clk or negedge pins.resetN) begin
    if (!pins.resetN) begin
      openBanks <= '0;
      ckeQ      <= 1'b0;
      modeOp    <= '0;
      modeSel   <= '0;
      fullBurst <= 1'b1;
      termOn    <= 1'b0;
      maskNow   <= 1'b0;
      activePd  <= 1'b0;
    end else begin
      ckeQ    <= pins.cke;
      maskNow <= pins.dm;
      termOn  <= pins.odt && ckeQ;
      if (ckeQ && !pins.cke) begin
        activePd <= |openBanks;
      end
      // Command, bank and address inputs count only while awake and selected.
      if (pins.cke && ckeQ && !pins.csN) begin
        case (code)
          CODE_ACT: openBanks[pins.ba] <= 1'b1;
          CODE_PRE: begin
            if (pins.addr[AP_BIT]) openBanks <= '0;
            else openBanks[pins.ba] <= 1'b0;
          end
          CODE_RD, CODE_WR: begin
            fullBurst <= !otfOn || pins.addr[BC_BIT];
            if (pins.addr[AP_BIT]) openBanks[pins.ba] <= 1'b0;
          end
          CODE_MRS: begin
            modeSel <= pins.ba[1:0];
            modeOp  <= pins.addr;
          end
          default: ;
        endcase
      end
    end
  end
endmodule : ddr3_dev_model

// ==== tb/tb_ddr3_ca_ctrl.sv ====
// Self-checking bench for the DDR3 command/address controller.
// Assumes a single 100 MHz clock and a device model on the pins.
`timescale 1ns/10ps
module tb_ddr3_ca_ctrl;
  import ddr3_ca_pkg::*;
  logic clk, rst, ce, cmdValid, otfChopEn, memResetReq, odtReq, wrMask;
  logic cmdReady, cmdReject, pdActive, fullBurst, pdX, chop;
  cmdReq_t              req;
  ddrPins_t             pins;
  logic [NUM_BANKS-1:0] openBanks, open;
  logic [ADDR_W-1:0]    modeOp;
  logic [1:0]           modeSel;
  logic [31:0]          seed;
  int errors, checks, cycles, mode;

  ddr3_ca_ctrl i_ddr3_ca_ctrl (.clk(clk), .rst(rst), .ce(ce), .req(req),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdReject(cmdReject),
    .otfChopEn(otfChopEn), .memResetReq(memResetReq), .odtReq(odtReq),
    .wrMask(wrMask), .pins(pins), .pdActive(pdActive));
  ddr3_dev_model i_ddr3_dev_model (.clk(clk), .pins(pins), .otfOn(otfChopEn),
    .openBanks(openBanks), .modeOp(modeOp), .modeSel(modeSel),
    .fullBurst(fullBurst));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input string nm, input logic [31:0] e, s);
    checks++;
    if (e !== s) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic finish_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // Drives one request at the current edge; the pins are judged after the
  // taking edge while the next request may already be presented.
  task automatic issue(input cmdReq_t r);
    logic rej, useA, useB, eo, ed, ot, pd;
    logic [3:0] cmd;
    logic [2:0] eb;
    logic [ADDR_W-1:0] ea;
    int m0, m1;
    rej = 1'b0; useA = 1'b0; useB = 1'b0; cmd = 4'hF; eb = r.bank;
    ea = r.addr; eo = rnd() % 2; ed = rnd() % 2; ot = chop; m0 = mode;
    if (mode == 1) begin
      if (r.op == OP_PDX) mode = 0; else rej = 1'b1;
    end else if (mode == 2) begin
      if (r.op == OP_SRX) mode = 0; else rej = 1'b1;
    end else case (r.op)
      OP_ACT: if (open[r.bank]) rej = 1'b1; else begin
        cmd = {1'b0, CODE_ACT}; useA = 1'b1; useB = 1'b1; open[r.bank] = 1'b1;
      end
      OP_RD, OP_WR: if (!open[r.bank]) rej = 1'b1; else begin
        cmd = {1'b0, (r.op == OP_RD) ? CODE_RD : CODE_WR};
        useA = 1'b1; useB = 1'b1; ea[AP_BIT] = r.autoPre;
        ea[BC_BIT] = ot ? !r.burstChop : 1'b1;
        if (r.autoPre) open[r.bank] = 1'b0;
      end
      OP_PRE, OP_PREA: begin
        cmd = {1'b0, CODE_PRE}; useA = 1'b1; useB = (r.op == OP_PRE);
        ea = '0; ea[AP_BIT] = !useB;
        if (useB) open[r.bank] = 1'b0; else open = '0;
      end
      OP_MRS, OP_REF, OP_SRE: if (|open) rej = 1'b1; else if (r.op == OP_MRS)
      begin
        cmd = {1'b0, CODE_MRS}; useA = 1'b1; useB = 1'b1;
        eb = {1'b0, r.bank[1:0]};
      end else begin
        cmd = {1'b0, CODE_REF};
        if (r.op == OP_SRE) mode = 2;
      end
      OP_NOP: cmd = {1'b0, CODE_NOP};
      OP_PDE: begin mode = 1; pdX = |open; end
      default: rej = 1'b1;
    endcase
    m1 = mode; pd = (mode == 1) && pdX;
    req <= r; cmdValid <= 1'b1; odtReq <= eo; wrMask <= ed;
    @(posedge clk);
    fork begin
      #1;
      check("csN", cmd[3], pins.csN);
      if (!cmd[3])
        check("code", cmd[2:0], {pins.rasN, pins.casN, pins.weN});
      check("cke", m1 == 0, pins.cke);
      check("reject", rej, cmdReject);
      check("pdActive", pd, pdActive);
      if (useB) check("ba", eb, pins.ba);
      if (useA) check("addr", ea, pins.addr);
      check("dm", ed, pins.dm);
      if (m0 == 0 && m1 == 0) check("odt", eo, pins.odt);
    end join_none
  endtask : issue

  task automatic gap(input int n);
    cmdValid <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : gap

  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hang short well beyond the expected few hundred cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      finish_test();
    end
  end

  // Reset checks, hand-picked corners, a random mix, then a memory reset.
  initial begin
    seed = 32'h9265; rst = 1'b1; ce = 1'b1; cmdValid = 1'b0; mode = 0;
    otfChopEn = 1'b1; memResetReq = 1'b0; odtReq = 1'b0; wrMask = 1'b0;
    req = '0; open = '0; pdX = 1'b0; chop = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    check("resetPins", PINS_RESET, pins);
    check("ready", 1'b0, cmdReady);
    @(posedge clk) rst <= 1'b0;
    @(posedge clk);
    #1;
    check("resetN", 3'h7, {pins.resetN, pins.cke, cmdReady});
    @(posedge clk);
    issue('{OP_MRS, 3'h7, 15'h1234, 1'b0, 1'b0});
    gap(3);
    check("modeSel", 2'h3, modeSel);
    check("modeOp", 15'h1234, modeOp);
    issue('{OP_ACT, 3'h5, 15'h7FFF, 1'b0, 1'b0});
    issue('{OP_ACT, 3'h5, 15'h0001, 1'b0, 1'b0});
    issue('{OP_MRS, 3'h0, 15'h0000, 1'b0, 1'b0});
    issue('{OP_RD, 3'h5, 15'h0000, 1'b1, 1'b1});
    gap(2);
    check("fullBurst", 1'b0, fullBurst);
    issue('{OP_WR, 3'h5, 15'h0003, 1'b0, 1'b0});
    // With the enable low a valid request must leave every flop as it was,
    // including the reject pulse of the write just refused.
    ce <= 1'b0;
    req <= '{OP_ACT, 3'h2, 15'h0002, 1'b0, 1'b0};
    cmdValid <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("frozen", 3'h7, {pins.csN, cmdReject, pins.cke});
    @(posedge clk) ce <= 1'b1;
    repeat (300) begin
      // The expectation must use the chop setting that the design will see.
      chop = 1'(rnd());
      otfChopEn <= chop;
      issue('{cmdOp_t'(rnd() % 12), rnd() % 8, rnd() % 32768, rnd() % 2,
        rnd() % 2});
    end
    gap(3);
    check("banks", open, openBanks);
    memResetReq <= 1'b1;
    @(posedge clk);
    #1;
    check("memReset", 2'h0, {pins.resetN, pins.cke});
    @(posedge clk) memResetReq <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("banksClr", 8'h00, openBanks);
    finish_test();
  end
endmodule : tb_ddr3_ca_ctrl
